//--- src/value_encoder_defines.vh
// constants of the analog value word encoder
// assumes inclusion by bare name from the design files in src/
// Overview of operation
// - one 16-bit word, bit 15 sign
// - magnitude in bits 14..4, low four zero except in 32767
// - above overdrive band gives 32767
// - below underdrive band gives -32768
// - invalid configuration gives 32767
// - out-of-range output value drives zero
// - bipolar 10V: +/-10V maps to +/-27648
// - bipolar 10V codes linearly to 32511/-32512
// - unipolar 10V codes down to -4864
// - bipolar 20mA: same scaling and bands
// - unipolar 20mA codes down to -4864
// - new conversion about every millisecond
`ifndef VALUE_ENCODER_DEFINES_VH
`define VALUE_ENCODER_DEFINES_VH
// range selections
`define RANGE_BIP_10V 3'h0
`define RANGE_UNI_10V 3'h1
`define RANGE_BIP_20MA 3'h2
`define RANGE_UNI_20MA 3'h3
// codes
`define CODE_OVERFLOW 16'h7FFF
`define CODE_UNDERFLOW 16'h8000
`define CODE_NOMINAL 16'h6C00
`define CODE_OVER_TOP 16'h7EFF
`define CODE_BIP_BOTTOM 16'h8100
`define CODE_UNI_BOTTOM 16'hED00
`define CODE_ZERO 16'h0000
// field layout
`define SIGN_POS 15
`define LOW_ZERO_BITS 4
// refresh period
`define REFRESH_US 1000
`define CLK_MHZ 40
`define REFRESH_CYCLES (`REFRESH_US * `CLK_MHZ)
`endif

//--- src/sample_fifo.v
// small synchronous fifo holding raw converter samples
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps
module sample_fifo #(
    parameter WIDTH = 19,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_in_valid,
    output wire o_in_ready,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_out_valid,
    input wire i_out_ready,
    output wire [WIDTH-1:0] o_out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr;
    wire do_rd;
    // depth held at the count's own width, so the full compare drops no bits
    localparam [AW:0] FULL_COUNT = DEPTH;

    // honest flags from the occupancy count
    assign o_in_ready = (count != FULL_COUNT);
    assign o_out_valid = (count != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_ptr];
    assign do_wr = i_in_valid && o_in_ready;
    assign do_rd = o_out_valid && i_out_ready;

    // storage and pointers
    always @(posedge i_clk) begin
        if (do_wr) begin
            mem[wr_ptr] <= i_in_data;
        end
        if (i_sys_rst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd && !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sample_fifo

//--- src/analog_value_word_encoder.v
// encoder of analog readings into signed 16-bit process words
// assumes the front end delivers 18-bit raw samples already scaled so
// that 27648 is full nominal scale; raw sits beyond the 16-bit code space
`timescale 1ns/1ps
`include "value_encoder_defines.vh"
module analog_value_word_encoder #(
    parameter RAW_W = 18,
    parameter FIFO_DEPTH = 8,
    parameter REFRESH_CYCLES = `REFRESH_CYCLES
) (
    input wire i_clk,
    input wire i_sys_rst,
    input wire i_sample_valid,
    input wire [RAW_W-1:0] i_sample_raw,
    output reg o_sample_ready,
    input wire [2:0] i_range_sel,
    input wire i_config_ok,
    output reg [15:0] o_value_word,
    output reg o_sign_flag,
    output reg o_word_strobe,
    input wire i_out_valid_range,
    input wire [15:0] i_out_value,
    output reg [15:0] o_out_drive
);
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire [RAW_W-1:0] fifo_out_data;
    reg [31:0] tick_count;
    reg tick;
    wire take;
    reg [15:0] next_word;

    // signed compare helper, used for each band edge
    function below;
        input [RAW_W-1:0] raw;
        input [15:0] edge_code;
        begin
            below = ($signed(raw) < $signed({{(RAW_W-16){edge_code[15]}}, edge_code}));
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // raw samples queue until the next refresh tick
    sample_fifo #(.WIDTH(RAW_W), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
        .i_clk(i_clk),
        .i_sys_rst(i_sys_rst),
        .i_in_valid(i_sample_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(i_sample_raw),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(take),
        .o_out_data(fifo_out_data)
    );
    // drain only on tick, so a fast front end sees back-pressure
    assign take = tick;

    ////////////////////////////////////////////////////////////////////////
    // millisecond refresh divider
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            tick_count <= 32'h00000000;
            tick <= 1'b0;
        end else if (tick_count >= REFRESH_CYCLES - 1) begin
            tick_count <= 32'h00000000;
            tick <= 1'b1;
        end else begin
            tick_count <= tick_count + 32'h00000001;
            tick <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // banding and clamping of the oldest queued sample
    always @* begin
        next_word = `CODE_ZERO;
        if (!i_config_ok || i_range_sel > `RANGE_UNI_20MA) begin
            next_word = `CODE_OVERFLOW;
        end else if (!below(fifo_out_data, `CODE_OVER_TOP + 16'h0001)) begin
            next_word = `CODE_OVERFLOW;
        end else if (i_range_sel == `RANGE_BIP_10V || i_range_sel == `RANGE_BIP_20MA) begin
            // bipolar: linear to -32512 then underflow
            if (below(fifo_out_data, `CODE_BIP_BOTTOM)) begin
                next_word = `CODE_UNDERFLOW;
            end else begin
                next_word = fifo_out_data[15:0];
            end
        end else begin
            // unipolar: linear only to -4864
            if (below(fifo_out_data, `CODE_UNI_BOTTOM)) begin
                next_word = `CODE_UNDERFLOW;
            end else begin
                next_word = fifo_out_data[15:0];
            end
        end
        // eleven bits plus sign: clear the low nibble of scaled values
        if (next_word != `CODE_OVERFLOW && next_word != `CODE_UNDERFLOW) begin
            next_word = {next_word[15:`LOW_ZERO_BITS], 4'h0};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // whole-word register, written only on a refresh tick with data
    always @(posedge i_clk) begin
        if (i_sys_rst) begin
            o_value_word <= `CODE_ZERO;
            o_sign_flag <= 1'b0;
            o_word_strobe <= 1'b0;
            o_sample_ready <= 1'b0;
            o_out_drive <= `CODE_ZERO;
        end else begin
            o_sample_ready <= fifo_in_ready;
            o_word_strobe <= tick && fifo_out_valid;
            if (tick && fifo_out_valid) begin
                o_value_word <= next_word;
                o_sign_flag <= next_word[`SIGN_POS];
            end
            // output side: out-of-range command drives zero
            if (i_out_valid_range) begin
                o_out_drive <= i_out_value;
            end else begin
                o_out_drive <= `CODE_ZERO;
            end
        end
    end
endmodule // analog_value_word_encoder

//--- verif/encoder_checker.sv
// checker for the encoder word and drive outputs
// assumes bind onto the encoder top; refresh of at least 9 cycles
`timescale 1ns/1ps
module encoder_checker (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic [2:0] i_range_sel,
    input wire logic i_config_ok,
    input wire logic i_out_valid_range,
    input wire logic [15:0] o_value_word,
    input wire logic o_sign_flag,
    input wire logic o_word_strobe,
    input wire logic [15:0] o_out_drive
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    ////////////////////////////////////////////////////////////
    // quiet gap after a word; the bench refresh leaves room
    sequence quiet_gap;
        !o_word_strobe [*8];
    endsequence
    sequence uni_word;
        o_word_strobe && $past(i_range_sel[0]);
    endsequence
    a_sign_copy: assert property (o_sign_flag == o_value_word[15])
        else $error("sign flag");
    a_low_zero: assert property (o_value_word != 16'h7FFF |-> o_value_word[3:0] == 4'h0)
        else $error("low bits");
    a_refresh_gap: assert property (o_word_strobe |=> quiet_gap)
        else $error("strobe gap");
    a_word_hold: assert property (!o_word_strobe |-> $stable(o_value_word))
        else $error("word moved");
    a_out_zero: assert property (!i_out_valid_range |=> o_out_drive == 16'h0000)
        else $error("drive");
    a_cfg_error: assert property (o_word_strobe && !$past(i_config_ok) |-> o_value_word == 16'h7FFF)
        else $error("cfg code");
    a_over_cap: assert property (o_word_strobe |-> o_value_word == 16'h7FFF || $signed(o_value_word) <= 32511)
        else $error("over cap");
    a_uni_floor: assert property (uni_word |-> o_value_word == 16'h8000 || $signed(o_value_word) >= -4864)
        else $error("uni floor");
endmodule // encoder_checker
bind analog_value_word_encoder encoder_checker i_encoder_checker(.i_clk, .i_sys_rst,
    .i_range_sel, .i_config_ok, .i_out_valid_range, .o_value_word, .o_sign_flag,
    .o_word_strobe, .o_out_drive);

//--- verif/front_end_model.sv
// converter front end offering one raw sample per request
// assumes registered ready from the encoder
`timescale 1ns/1ps
module front_end_model (
    input wire logic i_clk,
    input wire logic i_sys_rst,
    input wire logic i_go,
    input wire logic [17:0] i_raw,
    input wire logic i_ready,
    output logic o_valid,
    output logic [17:0] o_raw
);
    // held until taken; idle raw flips so stale data never looks valid
    always @(posedge i_clk) begin
        if (i_sys_rst)
            o_valid <= 1'b0;
        else if (o_valid && i_ready) begin
            o_valid <= 1'b0;
            o_raw <= ~o_raw;
        end else if (i_go) begin
            o_valid <= 1'b1;
            o_raw <= i_raw;
        end
    end
endmodule // front_end_model

//--- verif/analog_value_word_encoder_bench.sv
// bench for the encoder
// assumes src/ design and verif/ models
`timescale 1ns/1ps
module analog_value_word_encoder_bench;
    logic i_clk = 0, i_sys_rst = 1, go = 0, cfg = 1, oo = 0;
    logic [17:0] raw = 18'h00000;
    logic [2:0] rs = 3'h0;
    logic [15:0] ov = 16'h0000;
    logic fv, rdy, sg, stb;
    logic [17:0] fr;
    logic [15:0] word, drive;
    int errors = 0, total_checks = 0, cyc = 0;
    int cr[10] = '{32511, 32512, -32512, -32513, -4864, -4865, -32513, 27648, -27648, 99};
    logic [2:0] cs[10] = '{0, 0, 2, 2, 1, 3, 3, 3, 0, 5};
    always #12.5 i_clk = ~i_clk;
    front_end_model i_front_end_model(.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_go(go),
        .i_raw(raw), .i_ready(rdy), .o_valid(fv), .o_raw(fr));
    analog_value_word_encoder #(.REFRESH_CYCLES(16)) i_analog_value_word_encoder(
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sample_valid(fv), .i_sample_raw(fr),
        .o_sample_ready(rdy), .i_range_sel(rs), .i_config_ok(cfg), .o_value_word(word),
        .o_sign_flag(sg), .o_word_strobe(stb), .i_out_valid_range(oo), .i_out_value(ov),
        .o_out_drive(drive));
    ////////////////////////////////////////////////////////////
    // expected word from range bands
    function automatic logic [15:0] exp_word(int r, logic [2:0] s, logic ok);
        if (!ok || s > 3'h3 || r > 32511)
            return 16'h7FFF;
        if (r < (s[0] ? -4864 : -32512))
            return 16'h8000;
        return r[15:0] & 16'hFFF0;
    endfunction
    task automatic chk(string what, logic [15:0] e, logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // one sample, waited out to its strobe
    task automatic run_one(int r, logic [2:0] s, logic ok);
        int n;
        logic [15:0] e;
        e = exp_word(r, s, ok);
        @(posedge i_clk);
        #1;
        chk("ready", 16'h0001, {15'h0000, rdy});
        @(posedge i_clk);
        raw <= r[17:0];
        rs <= s;
        cfg <= ok;
        ov <= 16'($urandom);
        oo <= 1'($urandom);
        go <= 1'b1;
        @(posedge i_clk);
        go <= 1'b0;
        n = 0;
        #1;
        while (stb !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        chk("word", e, word);
        chk("sign", {15'h0000, e[15]}, {15'h0000, sg});
        chk("drive", oo ? ov : 16'h0000, drive);
    endtask
    initial begin
        void'($urandom(32'h9B23));
        repeat (8) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        foreach (cr[i]) run_one(cr[i], cs[i], 1'b1);
        run_one(1000, 3'h0, 1'b0);
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        #1;
        chk("reset word", 16'h0000, word);
        repeat (20) run_one(int'($urandom_range(262143)) - 131072, 3'($urandom_range(4)), 1'b1);
        close_out();
    end
    // hang guard
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            close_out();
        end
    end
endmodule // analog_value_word_encoder_bench
